// *** design/backplane_requester.sv ***
// Backplane arbiter, requester with four release modes, and master interface.
// Assumes processor and backplane inputs are synchronous to clk; lines
// ending in _n are active low; open-drain lines come as out/oe pairs.
//
// Notes on behaviour
// - Arbiter grants level three when bus idle.
// - Arbiter drops grant once bus-busy asserted.
// - Master interface enabled only after owning bus.
// - Request at jumpered level after processor strobe.
// - Busy bus stalls, or times out if enabled.
// - Take bus-busy once selected grant arrives.
// - Drive address, modifier, direction with address strobe, then data strobes.
// - Cycle stays open until acknowledge, error or timeout.
// - Pass grant on when bus not needed.
// - Other levels pass grant straight through.
// - Still owning means no new arbitration.
// - Never mode keeps bus until mode changes.
// - Clear mode releases only on bus clear or halt.
// - Request mode releases on any other request.
// - Reset selects release-on-request mode.
// - Done mode drops busy right after strobe.
// - Request/clear modes release only between cycles, in idle.
// - Modifier codes by privilege, space and range.
// - Jumpered, control bit 7 inverts modifier bit 3.
// - Top address page uses short I/O modifier.
// - Modifier bit 5 is never driven.
// - Data strobe delay differs for read, write.
// - Processor waits follow slave acknowledge time.
// - Arbiter works only as system controller.
`timescale 1ns/1ps
module backplane_requester
#(
   parameter int TIMEOUT_CYC = bus_pkg::TIMEOUT_CYC // Local timeout in cycles
)
(
   input  wire logic        clk,               // 200 MHz clock
   input  wire logic        reset,             // Synchronous, active high
   // APB
   input  wire logic        psel,              // Select
   input  wire logic        penable,           // Access phase
   input  wire logic        pwrite,            // Write
   input  wire logic [11:0] paddr,             // Byte address
   input  wire logic [31:0] pwdata,            // Write data
   output logic      [31:0] prdata,            // Read data
   output logic             pready,            // Ready
   output logic             pslverr,           // Unmapped address
   // Processor side
   input  wire logic        processor_address_strobe_n, // Processor strobe
   input  wire logic        cpu_vme_sel,       // Access targets backplane
   input  wire logic [23:1] cpu_addr,          // Processor address
   input  wire logic [2:0]  cpu_fc,            // Function code
   input  wire logic        cpu_read,          // 1 read, 0 write
   input  wire logic        cpu_uds_n,         // Upper data strobe
   input  wire logic        cpu_lds_n,         // Lower data strobe
   input  wire logic        cpu_halt_n,        // Processor halted
   output logic             cpu_dtack_n,       // Acknowledge to processor
   output logic             cpu_berr_n,        // Bus error to processor
   // Straps
   input  wire logic        system_controller, // Arbiter enable
   input  wire logic        request_level_jumper_a, // Level bit 0
   input  wire logic        request_level_jumper_b, // Level bit 1
   input  wire logic        modifier_bit_jumper, // 1: bit 3 from control
   input  wire logic        timeout_en,        // Local timeout enable
   // Arbitration
   input  wire logic [3:0]  request_in_n,      // Request lines, wire level
   output logic      [3:0]  request_out_n,     // Request drive value
   output logic      [3:0]  request_oe,        // Request drive enable
   input  wire logic [3:0]  grant_in_n,        // Grant-in daisy chain
   output logic      [3:0]  grant_out_n,       // Grant-out daisy chain
   output logic             level_three_grant_in_n, // Arbiter grant
   output logic             arb_grant_oe,      // Arbiter grant enable
   input  wire logic        busy_in_n,         // Bus-busy wire level
   output logic             busy_out_n,        // Bus-busy drive value
   output logic             busy_oe,           // Bus-busy drive enable
   input  wire logic        bus_clear_n,       // Bus clear
   // Master interface
   output logic      [23:1] vme_addr,          // Address
   output logic      [4:0]  vme_am,            // Modifier bits 4..0
   output logic             vme_write_n,       // Direction
   output logic             vme_as_n,          // Address strobe
   output logic             vme_ds0_n,         // Lower data strobe
   output logic             vme_ds1_n,         // Upper data strobe
   output logic             master_oe,         // Master lines enable
   input  wire logic        vme_dtack_n,       // Slave acknowledge
   input  wire logic        vme_berr_n         // Slave bus error
);

   localparam int ARB_CYC  = bus_pkg::ARB_GRANT_CYC;
   localparam int TAKE_CYC = bus_pkg::TAKE_BUS_CYC;
   localparam int PASS_CYC = bus_pkg::PASS_GRANT_CYC;
   localparam int REQ_CYC  = bus_pkg::REQ_AFTER_AS_CYC;

   bus_pkg::master_state_type state_q;
   bus_pkg::release_mode_type mode_q;
   logic        am3_ctrl_q;
   logic        own_q;
   logic        req_q;
   logic        pass_q;
   logic        arb_q;
   logic        tmo_q;
   logic [15:0] to_cnt_q;
   logic        ack_q;
   logic        berr_q;
   logic        ds_go;
   logic [1:0]  level;
   logic        need;
   logic        sel_grant;
   logic        others_req;
   logic        release_now;
   logic        timeout_hit;
   logic        apb_wr;
   logic        addr_ok;

   function automatic logic [4:0] am_code(input logic [23:1] a, input logic [2:0] fc,
                                          input logic jmp, input logic bit7);
      logic [4:0] c;
      if (a[23:16] == bus_pkg::SHORT_IO_PAGE)
         c = fc[bus_pkg::FC_SUPER_BIT] ? bus_pkg::AM_SUP_SHORT : bus_pkg::AM_USR_SHORT;
      else if (fc[bus_pkg::FC_SUPER_BIT])
         c = fc[bus_pkg::FC_PROG_BIT] ? bus_pkg::AM_SUP_PROG : bus_pkg::AM_SUP_DATA;
      else
         c = fc[bus_pkg::FC_PROG_BIT] ? bus_pkg::AM_USR_PROG : bus_pkg::AM_USR_DATA;
      if (jmp)
         c[bus_pkg::AM_BIT3] = !bit7;
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Decode

   assign level       = {request_level_jumper_b, request_level_jumper_a};
   assign need        = !processor_address_strobe_n && cpu_vme_sel;
   assign sel_grant   = !grant_in_n[level];
   assign others_req  = |(~request_in_n & ~request_oe);
   assign timeout_hit = timeout_en && (to_cnt_q == 16'(TIMEOUT_CYC - 1));

   always_comb
   begin
      release_now = 1'b0;
      if (state_q == bus_pkg::st_idle)
      begin
         unique case (mode_q)
            bus_pkg::release_never_mode:      release_now = 1'b0;
            bus_pkg::release_on_clear_mode:   release_now = !bus_clear_n || !cpu_halt_n;
            bus_pkg::release_on_request_mode: release_now = others_req || !cpu_halt_n;
            bus_pkg::release_when_done_mode:  release_now = 1'b1;
         endcase
      end
      else if (mode_q == bus_pkg::release_when_done_mode && state_q != bus_pkg::st_req)
         release_now = !vme_as_n;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers over APB

   assign apb_wr  = psel && penable && pwrite;
   assign addr_ok = (paddr == bus_pkg::CTRL_ADDR) || (paddr == bus_pkg::STATUS_ADDR);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mode_q     <= bus_pkg::MODE_RESET;
         am3_ctrl_q <= 1'b0;
      end
      else if (apb_wr && paddr == bus_pkg::CTRL_ADDR)
      begin
         mode_q     <= bus_pkg::release_mode_type'(pwdata[bus_pkg::MODE_LSB +: 2]);
         am3_ctrl_q <= pwdata[bus_pkg::AM3_CTRL_BIT];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
      begin
         prdata <= 32'h0000_0000;
         if (paddr == bus_pkg::CTRL_ADDR)
         begin
            prdata[bus_pkg::MODE_LSB +: 2]  <= mode_q;
            prdata[bus_pkg::AM3_CTRL_BIT]   <= am3_ctrl_q;
         end
         else if (paddr == bus_pkg::STATUS_ADDR)
         begin
            prdata[bus_pkg::ST_OWN_BIT]       <= own_q;
            prdata[bus_pkg::ST_REQ_BIT]       <= req_q;
            prdata[bus_pkg::ST_PASS_BIT]      <= pass_q;
            prdata[bus_pkg::ST_TMO_BIT]       <= tmo_q;
            prdata[bus_pkg::ST_STATE_LSB +: 3] <= state_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Level-three arbiter

   always_ff @(posedge clk)
   begin
      if (reset || !system_controller)
         arb_q <= 1'b0;
      else if (arb_q && !busy_in_n)
         arb_q <= 1'b0;
      else if (!request_in_n[bus_pkg::LEVEL_THREE] && busy_in_n)
         arb_q <= 1'b1;
   end

   assign level_three_grant_in_n = !arb_q;
   assign arb_grant_oe           = system_controller;

   ////////////////////////////////////////////////////////////////////////////////
   // Requester and grant chain

   always_ff @(posedge clk)
   begin
      if (reset)
         pass_q <= 1'b0;
      else if (!sel_grant)
         pass_q <= 1'b0;
      else if (!need && !req_q && state_q == bus_pkg::st_idle)
         pass_q <= 1'b1;
   end

   always_comb
   begin
      for (int i = 0; i < 4; i++)
         grant_out_n[i] = (2'(i) == level) ? !pass_q : grant_in_n[i];
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         req_q <= 1'b0;
      else if (own_q || timeout_hit || state_q != bus_pkg::st_req)
         req_q <= 1'b0;
      else
         req_q <= 1'b1;
   end

   assign request_out_n = 4'h0;
   assign request_oe    = req_q ? (4'h1 << level) : 4'h0;

   always_ff @(posedge clk)
   begin
      if (reset)
         own_q <= 1'b0;
      else if (!own_q && state_q == bus_pkg::st_req && req_q && sel_grant && !pass_q)
         own_q <= 1'b1;
      else if (release_now)
         own_q <= 1'b0;
   end

   assign busy_out_n = 1'b0;
   assign busy_oe    = own_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Master cycle

   always_ff @(posedge clk)
   begin
      if (reset)
         state_q <= bus_pkg::st_idle;
      else
      begin
         unique case (state_q)
            bus_pkg::st_idle:
               if (need)
                  state_q <= own_q ? bus_pkg::st_addr : bus_pkg::st_req;
            bus_pkg::st_req:
               if (timeout_hit)
                  state_q <= bus_pkg::st_done;
               else if (own_q)
                  state_q <= bus_pkg::st_addr;
            bus_pkg::st_addr:
               if (timeout_hit)
                  state_q <= bus_pkg::st_done;
               else if (ds_go)
                  state_q <= bus_pkg::st_data;
            bus_pkg::st_data:
               if (!vme_dtack_n || !vme_berr_n || timeout_hit)
                  state_q <= bus_pkg::st_done;
            bus_pkg::st_done:
               if (processor_address_strobe_n)
                  state_q <= bus_pkg::st_idle;
            default:
               state_q <= bus_pkg::st_idle;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset || state_q == bus_pkg::st_idle || state_q == bus_pkg::st_done)
         to_cnt_q <= 16'h0000;
      else
         to_cnt_q <= to_cnt_q + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         tmo_q <= 1'b0;
      else if (timeout_hit && state_q != bus_pkg::st_done)
         tmo_q <= 1'b1;
      else if (state_q == bus_pkg::st_req)
         tmo_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (reset || state_q == bus_pkg::st_idle)
      begin
         ack_q  <= 1'b0;
         berr_q <= 1'b0;
      end
      else if (state_q == bus_pkg::st_data && !vme_dtack_n)
         ack_q <= 1'b1;
      else if (state_q != bus_pkg::st_done && (timeout_hit || (state_q == bus_pkg::st_data
               && !vme_berr_n)))
         berr_q <= 1'b1;
   end

   assign cpu_dtack_n = !ack_q;
   assign cpu_berr_n  = !berr_q;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         vme_addr    <= 23'h000000;
         vme_am      <= 5'h00;
         vme_write_n <= 1'b1;
      end
      else if (state_q != bus_pkg::st_addr && state_q != bus_pkg::st_data)
      begin
         vme_addr    <= cpu_addr;
         vme_am      <= am_code(cpu_addr, cpu_fc, modifier_bit_jumper, am3_ctrl_q);
         vme_write_n <= cpu_read;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         vme_as_n  <= 1'b1;
         vme_ds0_n <= 1'b1;
         vme_ds1_n <= 1'b1;
         master_oe <= 1'b0;
      end
      else
      begin
         master_oe <= state_q == bus_pkg::st_addr || state_q == bus_pkg::st_data;
         vme_as_n  <= !(state_q == bus_pkg::st_addr || state_q == bus_pkg::st_data);
         vme_ds0_n <= !(state_q == bus_pkg::st_data && !cpu_lds_n);
         vme_ds1_n <= !(state_q == bus_pkg::st_data && !cpu_uds_n);
      end
   end

   strobe_delay ds_delay
   (
      .clk      (clk),
      .reset    (reset),
      .start    (!vme_as_n && state_q == bus_pkg::st_addr),
      .is_write (!vme_write_n),
      .ds_go    (ds_go)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   arb_grant_a : assert property (@(posedge clk) disable iff (reset)
      system_controller && !arb_q && !request_in_n[3] && busy_in_n |-> ##[1:ARB_CYC] arb_q)
      else $error("arbiter grant late");

   arb_drop_a : assert property (@(posedge clk) disable iff (reset)
      arb_q && !busy_in_n |=> !arb_q)
      else $error("arbiter grant held under busy");

   master_own_a : assert property (@(posedge clk) disable iff (reset)
      state_q == bus_pkg::st_addr && $past(state_q) != bus_pkg::st_addr |-> $past(own_q))
      else $error("master enabled without mastership");

   request_a : assert property (@(posedge clk) disable iff (reset)
      state_q == bus_pkg::st_idle && need && !own_q |-> ##[1:REQ_CYC] req_q)
      else $error("request not raised");

   take_bus_a : assert property (@(posedge clk) disable iff (reset)
      state_q == bus_pkg::st_req && req_q && sel_grant && !pass_q |-> ##[1:TAKE_CYC] busy_oe)
      else $error("bus-busy not taken");

   cycle_open_a : assert property (@(posedge clk) disable iff (reset)
      state_q == bus_pkg::st_data && vme_dtack_n && vme_berr_n && !timeout_hit
      |=> state_q == bus_pkg::st_data)
      else $error("cycle closed without answer");

   pass_grant_a : assert property (@(posedge clk) disable iff (reset)
      sel_grant && !need && !req_q && state_q == bus_pkg::st_idle
      |-> ##[1:PASS_CYC] !grant_out_n[level])
      else $error("grant not passed on");

   never_keep_a : assert property (@(posedge clk) disable iff (reset)
      mode_q == bus_pkg::release_never_mode && own_q |=> own_q)
      else $error("mastership dropped in never mode");

   done_release_a : assert property (@(posedge clk) disable iff (reset)
      mode_q == bus_pkg::release_when_done_mode && $fell(vme_as_n) ##1
      mode_q == bus_pkg::release_when_done_mode |-> !own_q)
      else $error("busy held after strobe");

   win_c : cover property (@(posedge clk) $rose(own_q));
   pass_c : cover property (@(posedge clk) $rose(pass_q));
   timeout_c : cover property (@(posedge clk) $rose(tmo_q));
   ack_c : cover property (@(posedge clk) $rose(ack_q));

endmodule

// *** design/bus_pkg.sv ***
// Constants and types shared by the backplane requester and its strobe timer.
// Assumes a single 200 MHz clock; all times below are converted to cycles here.
package bus_pkg;

   typedef enum logic [1:0]
   {
      release_never_mode      = 2'b00,
      release_on_clear_mode   = 2'b01,
      release_on_request_mode = 2'b10,
      release_when_done_mode  = 2'b11
   } release_mode_type;

   typedef enum logic [2:0]
   {
      st_idle = 3'b000,
      st_req  = 3'b001,
      st_addr = 3'b010,
      st_data = 3'b011,
      st_done = 3'b100
   } master_state_type;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_NS          = 5;
   localparam int ARB_GRANT_NS    = 40;
   localparam int ARB_DROP_NS     = 80;
   localparam int REQ_AFTER_AS_NS = 70;
   localparam int TAKE_BUS_NS     = 100;
   localparam int PASS_GRANT_NS   = 50;
   localparam int DONE_RELEASE_NS = 65;
   localparam int READ_DS_MIN_NS  = 10;
   localparam int WRITE_DS_MIN_NS = 100;
   localparam int TIMEOUT_US      = 200;

   localparam int ARB_GRANT_CYC    = ARB_GRANT_NS / CLK_NS;
   localparam int ARB_DROP_CYC     = ARB_DROP_NS / CLK_NS;
   localparam int REQ_AFTER_AS_CYC = REQ_AFTER_AS_NS / CLK_NS;
   localparam int TAKE_BUS_CYC     = TAKE_BUS_NS / CLK_NS;
   localparam int PASS_GRANT_CYC   = PASS_GRANT_NS / CLK_NS;
   localparam int DONE_RELEASE_CYC = DONE_RELEASE_NS / CLK_NS;
   localparam int READ_DS_CYC      = (READ_DS_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRITE_DS_CYC     = (WRITE_DS_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int TIMEOUT_CYC      = TIMEOUT_US * 1000 / CLK_NS;

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   localparam logic [11:0] CTRL_ADDR    = 12'h000;
   localparam logic [11:0] STATUS_ADDR  = 12'h004;
   localparam int          MODE_LSB     = 0;
   localparam int          AM3_CTRL_BIT = 7;
   localparam int          ST_OWN_BIT   = 0;
   localparam int          ST_REQ_BIT   = 1;
   localparam int          ST_PASS_BIT  = 2;
   localparam int          ST_TMO_BIT   = 3;
   localparam int          ST_STATE_LSB = 4;
   localparam release_mode_type MODE_RESET = release_on_request_mode;

   ////////////////////////////////////////////////////////////////////////////////
   // Address modifier codes, bits 4..0 (bit 5 is left to the backplane pull-up)
   localparam logic [4:0] AM_SUP_PROG  = 5'h1E;
   localparam logic [4:0] AM_SUP_DATA  = 5'h1D;
   localparam logic [4:0] AM_USR_PROG  = 5'h1A;
   localparam logic [4:0] AM_USR_DATA  = 5'h19;
   localparam logic [4:0] AM_SUP_SHORT = 5'h0D;
   localparam logic [4:0] AM_USR_SHORT = 5'h09;
   localparam int         AM_BIT3      = 3;
   localparam logic [7:0] SHORT_IO_PAGE = 8'hFF;
   localparam int         FC_SUPER_BIT = 2;
   localparam int         FC_PROG_BIT  = 1;
   localparam logic [1:0] LEVEL_THREE   = 2'h3;

endpackage

// *** design/strobe_delay.sv ***
// Delay from backplane address strobe to data strobes.
// Assumes start stays high for the whole strobe phase of a cycle.
`timescale 1ns/1ps
module strobe_delay
(
   input  wire logic clk,      // System clock
   input  wire logic reset,    // Synchronous reset
   input  wire logic start,    // Address strobe is asserted
   input  wire logic is_write, // Cycle direction
   output logic      ds_go     // Data strobes may assert
);

   localparam logic [4:0] READ_CNT  = 5'(bus_pkg::READ_DS_CYC);
   localparam logic [4:0] WRITE_CNT = 5'(bus_pkg::WRITE_DS_CYC);

   logic [4:0] cnt_q;

   always_ff @(posedge clk)
   begin
      if (reset || !start)
      begin
         cnt_q <= 5'h00;
         ds_go <= 1'b0;
      end
      else if (!ds_go)
      begin
         cnt_q <= cnt_q + 5'h01;
         ds_go <= (cnt_q + 5'h01) >= (is_write ? WRITE_CNT : READ_CNT);
      end
   end

   read_delay_a : assert property (@(posedge clk) disable iff (reset)
      $rose(start) && !is_write |-> !ds_go [*2] ##1 ds_go)
      else $error("read data strobe delay wrong");

endmodule

// *** tb/far_side.sv ***
// Far side: other masters, arbiter grant wiring, one slave.
// Assumes the requester is strapped to level three.
`timescale 1ns/1ps
module far_side
(
   input  wire logic       clk,     // Clock
   input  wire logic [3:0] req_oe,  // Own request drive
   input  wire logic       busy_oe, // Own busy drive
   input  wire logic       gnt_n,   // Arbiter grant
   input  wire logic       gnt_oe,  // Grant drive
   input  wire logic [3:0] gout_n,  // Grant-out chain
   input  wire logic       ds_n,    // Data strobes high
   input  wire logic [3:0] oreq,    // Other requests
   input  wire logic       obusy,   // Other owner
   input  wire logic [2:0] gin,     // Low grant-ins
   input  wire logic [3:0] lat,     // Slave delay
   input  wire logic       err,     // Error answer
   output logic      [3:0] req_n,   // Request wires
   output logic      [3:0] grant_n, // Grant-in wires
   output logic            busy_n,  // Busy wire
   output logic            dtack_n, // Acknowledge
   output logic            berr_n,  // Bus error
   output logic            took     // Level 3 taken
);
   logic       held;
   logic [3:0] cnt;

   assign req_n   = ~(req_oe | (oreq & {~held, 3'h7}));
   assign grant_n = {~gnt_oe | gnt_n, gin};
   assign busy_n  = ~(busy_oe | obusy | held);

   initial
   begin
      {held, took, cnt, dtack_n, berr_n} = 8'h3;
   end
   // Level 3 master takes the bus on a passed grant
   always @(posedge clk)
   begin
      if (oreq[3] && !gout_n[3])
         {held, took} <= 2'h3;
      else if (!oreq[3])
         held <= 1'b0;
      cnt     <= ds_n ? 4'h0 : cnt + {3'h0, cnt != 4'hF};
      dtack_n <= ds_n || err || cnt < lat;
      berr_n  <= ds_n || !err || cnt < lat;
   end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the backplane requester.
// Assumes far_side.sv as far side; requester on level 3.
`timescale 1ns/1ps
module testbench;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        processor_address_strobe_n, cpu_vme_sel, cpu_read, cpu_uds_n, cpu_lds_n;
   logic        cpu_halt_n, cpu_dtack_n, cpu_berr_n, modifier_bit_jumper, timeout_en;
   logic [23:1] cpu_addr, vme_addr, a, cad;
   logic [2:0]  cpu_fc, gin;
   logic [3:0]  request_in_n, request_out_n, request_oe, grant_in_n, grant_out_n, oreq, lat;
   logic        level_three_grant_in_n, arb_grant_oe, busy_in_n, busy_out_n, busy_oe;
   logic        bus_clear_n, vme_write_n, vme_as_n, vme_ds0_n, vme_ds1_n, master_oe;
   logic        vme_dtack_n, vme_berr_n, obusy, err, b7, took, as_v, ds_v, rs_v, dok;
   logic [4:0]  vme_am, cam;
   logic [64:0] ae;
   logic [31:0] cq[$];
   logic [64:0] aq[$];
   int          err_total, checked, dcnt, i, m;

   backplane_requester #(.TIMEOUT_CYC(64)) DUT
   (
      .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .processor_address_strobe_n, .cpu_vme_sel, .cpu_addr, .cpu_fc, .cpu_read, .cpu_uds_n,
      .cpu_lds_n, .cpu_halt_n, .cpu_dtack_n, .cpu_berr_n, .system_controller(1'b1),
      .request_level_jumper_a(1'b1), .request_level_jumper_b(1'b1), .modifier_bit_jumper,
      .timeout_en, .request_in_n, .request_out_n, .request_oe, .grant_in_n, .grant_out_n,
      .level_three_grant_in_n, .arb_grant_oe, .busy_in_n, .busy_out_n, .busy_oe, .bus_clear_n,
      .vme_addr, .vme_am, .vme_write_n, .vme_as_n, .vme_ds0_n, .vme_ds1_n, .master_oe,
      .vme_dtack_n, .vme_berr_n
   );
   far_side PEER
   (
      .clk, .req_oe(request_oe), .busy_oe, .gnt_n(level_three_grant_in_n), .gnt_oe(arb_grant_oe),
      .gout_n(grant_out_n), .ds_n(vme_ds0_n & vme_ds1_n), .oreq, .obusy, .gin, .lat, .err,
      .req_n(request_in_n), .grant_n(grant_in_n), .busy_n(busy_in_n), .dtack_n(vme_dtack_n),
      .berr_n(vme_berr_n), .took
   );

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (g !== e)
      begin
         err_total++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic bound(input int k);
      if (k >= 400)
      begin
         cmp(0, k);
         print_verdict();
      end
   endtask
   function automatic logic [4:0] amx(input logic [23:1] x, input logic [2:0] f);
      amx = (x[23:16] == 8'hFF) ? {2'h1, f[2], 2'h1} : {2'h3, f[2], f[1] ? 2'h2 : 2'h1};
      if (modifier_bit_jumper && b7)
         amx[3] = 1'b0;
   endfunction
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                      input logic [32:0] e, input logic [31:0] mk);
      int k;
      if (!w)
         aq.push_back({mk, e});
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k == 0 || (k < 400 && pready !== 1'b1); k++) @(posedge clk);
      bound(k);
      {psel, penable} <= 2'h0;
      @(posedge clk);
   endtask
   task automatic cyc(input logic [23:1] x, input logic [2:0] f, input logic r,
                      input logic [1:0] rsp, input logic to);
      int k;
      cq.push_back(to ? 32'h2000_0000 : {1'b0, rsp, 1'b1, amx(x, f), x});
      lat <= 4'($urandom_range(6));
      {cpu_addr, cpu_fc, cpu_read, cpu_vme_sel} <= {x, f, r, 1'b1};
      {processor_address_strobe_n, cpu_uds_n, cpu_lds_n} <= 3'h0;
      for (k = 0; k < 400 && (cpu_dtack_n & cpu_berr_n) === 1'b1; k++) @(posedge clk);
      bound(k);
      {processor_address_strobe_n, cpu_uds_n, cpu_lds_n, cpu_vme_sel} <= 4'hE;
      for (k = 0; k < 400 && (cpu_dtack_n & cpu_berr_n) !== 1'b1; k++) @(posedge clk);
      bound(k);
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Result watcher
   always @(posedge clk)
   begin
      if (vme_as_n === 1'b0 && (vme_ds0_n & vme_ds1_n) === 1'b1)
         dcnt++;
      if (vme_as_n === 1'b1)
         dcnt = 0;
      if (vme_as_n === 1'b0 && as_v && master_oe)
         {cam, cad} = {vme_am, vme_addr};
      if ((vme_ds0_n & vme_ds1_n) === 1'b0 && ds_v)
         dok = vme_write_n ? dcnt >= 2 && dcnt <= 7 : dcnt >= 20 && dcnt <= 26;
      if ((cpu_dtack_n & cpu_berr_n) === 1'b0 && rs_v)
      begin
         cmp(cq.pop_front(), {1'b0, cpu_berr_n, cpu_dtack_n, dok, cam, cad});
         {dok, cam, cad} = 0;
      end
      if ((psel & penable & pready & !pwrite) === 1'b1)
      begin
         ae = aq.pop_front();
         cmp(ae[32:0], {pslverr, prdata & ae[64:33]});
      end
      {as_v, ds_v, rs_v} = {vme_as_n, vme_ds0_n & vme_ds1_n, cpu_dtack_n & cpu_berr_n};
   end

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      {reset, psel, penable, pwrite, paddr, pwdata, cpu_addr, cpu_fc} = {1'b1, 73'h0};
      {processor_address_strobe_n, cpu_vme_sel, cpu_read, cpu_uds_n, cpu_lds_n} = 5'h17;
      {cpu_halt_n, modifier_bit_jumper, timeout_en, bus_clear_n} = 4'h9;
      {oreq, obusy, gin, lat, err, b7, dok, cam, cad} = {5'h0, 3'h7, 35'h0};
      {as_v, ds_v, rs_v, err_total, checked, dcnt} = {3'h7, 96'h0};
      void'($urandom(32'h94894DC4));
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      apb(0, bus_pkg::CTRL_ADDR, 0, 33'h2, 32'hFF);
      apb(1, 12'h008, 32'h3, 0, 0);
      apb(0, 12'h008, 0, 33'h1_0000_0000, 32'hFFFF_FFFF);
      $display("test registers done");
      for (i = 0; i < 12; i++)
      begin
         a = 23'($urandom);
         a[23:16] = (i >= 8) ? 8'hFF : {1'b0, a[22:16]};
         cyc(a, {i[0], i[1], 1'b1}, i < 4 || i >= 8, 2'h2, 0);
      end
      err <= 1'b1;
      cyc(23'h1234, 3'h5, 1, 2'h1, 0);
      err <= 1'b0;
      {modifier_bit_jumper, b7} <= 2'h3;
      apb(1, bus_pkg::CTRL_ADDR, 32'h82, 0, 0);
      cyc(23'h7F_8010, 3'h7, 1, 2'h2, 0);
      $display("test cycles done");
      for (m = 0; m < 4; m++)
      begin
         apb(1, bus_pkg::CTRL_ADDR, m + 128, 0, 0);
         cyc(23'($urandom), 3'h5, 1, 2'h2, 0);
         oreq <= 4'h2;
         repeat (12) @(posedge clk);
         apb(0, bus_pkg::STATUS_ADDR, 0, {32'h0, m < 2}, 32'h1);
         bus_clear_n <= 1'b0;
         repeat (12) @(posedge clk);
         apb(0, bus_pkg::STATUS_ADDR, 0, {32'h0, m == 0}, 32'h1);
         {oreq, bus_clear_n} <= 5'h1;
      end
      apb(1, bus_pkg::CTRL_ADDR, 32'h82, 0, 0);
      cyc(23'h0100, 3'h6, 0, 2'h2, 0);
      cpu_halt_n <= 1'b0;
      repeat (12) @(posedge clk);
      apb(0, bus_pkg::STATUS_ADDR, 0, 33'h0, 32'h1);
      {cpu_halt_n, oreq, gin} <= {5'h18, 3'($urandom)};
      repeat (20) @(posedge clk);
      cmp(1, took);
      cmp(gin, grant_out_n[2:0]);
      oreq <= 4'h0;
      repeat (10) @(posedge clk);
      $display("test release done");
      {obusy, timeout_en} <= 2'h3;
      cyc(23'h2000, 3'h5, 1, 2'h1, 1);
      {obusy, timeout_en} <= 2'h0;
      repeat (20) @(posedge clk);
      $display("test timeout done");
      print_verdict();
   end
endmodule
